//--- core/relay_setting_checker_trip_gate.sv
// settings range / coherence checker and trip permission gate
// assumes a plain register port on sys_clk; trip and event inputs come from pins
// Functional notes
// - master trip authorization off blocks every trip output
// - separate enables for zone 1/2/3, line pickup and remote open trips
// - line pickup timer accepts 0..150 ms; 128 ms is only advised
// - out of step blocking timer accepts 40..200 ms
// - remote open detector timer accepts 0..150 ms
// - remote open timer may not exceed held zone 2 timer
// - zone 1 timer accepts 0..500 ms
// - zone 2 timer accepts 100..3000 ms
// - zone 3 timer accepts 100..10000 ms
// - zone 1 or 2 timer may not exceed zone 3 timer minus 20 ms
// - zone 1 or 2 reach may not exceed zone 3 reach
// - out of range or incoherent proposals are refused
// - reclose count at most three; zero disables recloser
// - reclose attempt delays accept 0.20..99.00 s
// - conditions delay, dwell and reset time accept 0.10..99.00 s
// - inhibit input enable cannot be cleared while wait conditions set
// - carrier input enable cannot be cleared under zone 2 acceleration
// - accumulated breaker value may not exceed programmed maximum
// - zone 2 reclose permission also permits reclose after remote open trip
// - each event cause has its own mask bit gating recording
// - with wait conditions, recloser holds off until inhibit clears
// - measuring units blocked below supervision threshold 0.15..3.00
// - under zone 1 extension, reset time may not be below zone 2 timer
// - zone 1 extension or zone 2 acceleration keeps scaled distance active
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps
module relay_setting_checker_trip_gate #(
    parameter int DATA_W = 32
) (
    input  wire logic                                sys_clk,
    input  wire logic                                reset_n,
    input  wire logic [7:0]                          addr,
    input  wire logic [DATA_W-1:0]                   wdata,
    input  wire logic                                wr_stb,
    input  wire logic                                rd_stb,
    output logic      [DATA_W-1:0]                   rdata,
    input  wire relay_settings_pkg::trip_req_t       trip_req,
    output relay_settings_pkg::trip_req_t            trip_out,
    input  wire logic [relay_settings_pkg::EVT_W-1:0] evt_in,
    output logic      [relay_settings_pkg::EVT_W-1:0] evt_record,
    input  wire logic                                phase_current_gt,
    output logic                                     distance_measuring_unit_en,
    input  wire logic                                reclose_init,
    input  wire logic                                reclose_inhibit,
    output logic                                     reclose_start,
    input  wire logic                                rod_tripped,
    input  wire logic                                z2_tripped,
    output logic                                     reclose_allowed,
    output logic                                     scaled_distance_active,
    output logic                                     reject_pulse
);

    // held settings
    logic [relay_settings_pkg::FLAGS_W-1:0] flags;
    relay_settings_pkg::scheme_t            scheme;
    logic [DATA_W-1:0] lpu_tmr, osb_tmr, rod_tmr, z1_tmr, z2_tmr, z3_tmr;
    logic [DATA_W-1:0] z1_reach, z2_reach, z3_reach, rcl_count;
    logic [DATA_W-1:0] rcl_t1, rcl_t2, rcl_t3, rcl_cond, dwell, reset_tm;
    logic [DATA_W-1:0] bkr_acc, bkr_max, supv_thr;
    logic [relay_settings_pkg::EVT_W-1:0] evt_mask;
    logic [3:0] status;
    logic last_reject, last_accept;

    // pin inputs: two-stage synchronisers
    relay_settings_pkg::trip_req_t        trip_s1, trip_s2;
    logic [relay_settings_pkg::EVT_W-1:0] evt_s1, evt_s2;
    logic [4:0] misc_s1, misc_s2;

    // range test used by every numeric setting except the reaches and the breaker accumulated value
    function automatic logic in_range(input logic [DATA_W-1:0] v,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // zone 3 timer minus margin, floored at zero
    function automatic logic [DATA_W-1:0] z3_less_margin(input logic [DATA_W-1:0] z3);
        z3_less_margin = (z3 > relay_settings_pkg::Z3_MARGIN) ?
                         z3 - relay_settings_pkg::Z3_MARGIN : '0;
    endfunction

    // synchronise asynchronous pins
    always_ff @(posedge sys_clk) begin
        trip_s1 <= trip_req;
        trip_s2 <= trip_s1;
        evt_s1  <= evt_in;
        evt_s2  <= evt_s1;
        misc_s1 <= {phase_current_gt, reclose_init, reclose_inhibit, rod_tripped, z2_tripped};
        misc_s2 <= misc_s1;
    end

    // proposal check, combinational on the written value
    logic ok;
    logic [DATA_W-1:0] proposed_flags;
    always_comb begin
        ok = 1'b1;
        proposed_flags = {{(DATA_W-relay_settings_pkg::FLAGS_W){1'b0}}, flags};
        case (addr)
            relay_settings_pkg::OFF_FLAGS: begin
                proposed_flags = wdata;
                if (wdata[relay_settings_pkg::FLG_WAIT_COND] &&
                    !wdata[relay_settings_pkg::FLG_INHIB_EN])
                    ok = 1'b0;
                if (scheme == relay_settings_pkg::SCH_Z2_ACCEL &&
                    !wdata[relay_settings_pkg::FLG_CARRIER_EN])
                    ok = 1'b0;
            end
            relay_settings_pkg::OFF_SCHEME: begin
                ok = (wdata <= 32'(relay_settings_pkg::SCH_Z2_ACCEL));
                if (wdata[1:0] == relay_settings_pkg::SCH_Z2_ACCEL &&
                    !flags[relay_settings_pkg::FLG_CARRIER_EN])
                    ok = 1'b0;
                if (wdata[1:0] == relay_settings_pkg::SCH_Z1_EXT && reset_tm < z2_tmr / 10)
                    ok = 1'b0;
            end
            relay_settings_pkg::OFF_LPU_TMR:
                ok = in_range(wdata, '0, relay_settings_pkg::LPU_MAX);
            relay_settings_pkg::OFF_OSB_TMR:
                ok = in_range(wdata, relay_settings_pkg::OSB_MIN,
                              relay_settings_pkg::OSB_MAX);
            relay_settings_pkg::OFF_ROD_TMR:
                ok = in_range(wdata, '0, relay_settings_pkg::ROD_MAX)
                     && wdata <= z2_tmr;
            relay_settings_pkg::OFF_Z1_TMR:
                ok = in_range(wdata, '0, relay_settings_pkg::Z1_TMR_MAX)
                     && wdata <= z3_less_margin(z3_tmr);
            relay_settings_pkg::OFF_Z2_TMR:
                ok = in_range(wdata, relay_settings_pkg::Z2_TMR_MIN,
                              relay_settings_pkg::Z2_TMR_MAX)
                     && wdata <= z3_less_margin(z3_tmr)
                     && wdata >= rod_tmr
                     && !(scheme == relay_settings_pkg::SCH_Z1_EXT &&
                          reset_tm < wdata / 10);
            relay_settings_pkg::OFF_Z3_TMR:
                ok = in_range(wdata, relay_settings_pkg::Z3_TMR_MIN,
                              relay_settings_pkg::Z3_TMR_MAX)
                     && z1_tmr <= z3_less_margin(wdata)
                     && z2_tmr <= z3_less_margin(wdata);
            relay_settings_pkg::OFF_Z1_REACH, relay_settings_pkg::OFF_Z2_REACH:
                ok = (wdata <= z3_reach);
            relay_settings_pkg::OFF_Z3_REACH:
                ok = (z1_reach <= wdata) && (z2_reach <= wdata);
            relay_settings_pkg::OFF_RCL_COUNT:
                ok = in_range(wdata, '0, relay_settings_pkg::RCL_CNT_MAX);
            relay_settings_pkg::OFF_RCL_T1, relay_settings_pkg::OFF_RCL_T2,
            relay_settings_pkg::OFF_RCL_T3:
                ok = in_range(wdata, relay_settings_pkg::RCL_T_MIN,
                              relay_settings_pkg::RCL_T_MAX);
            relay_settings_pkg::OFF_RCL_COND, relay_settings_pkg::OFF_DWELL:
                ok = in_range(wdata, relay_settings_pkg::RCL_MISC_MIN,
                              relay_settings_pkg::RCL_T_MAX);
            relay_settings_pkg::OFF_RESET_TM:
                ok = in_range(wdata, relay_settings_pkg::RCL_MISC_MIN,
                              relay_settings_pkg::RCL_T_MAX)
                     && !(scheme == relay_settings_pkg::SCH_Z1_EXT &&
                          wdata < z2_tmr / 10);
            relay_settings_pkg::OFF_BKR_ACC:
                ok = (wdata <= bkr_max);
            relay_settings_pkg::OFF_BKR_MAX:
                ok = in_range(wdata, '0, relay_settings_pkg::BKR_MAX_LIM)
                     && bkr_acc <= wdata;
            relay_settings_pkg::OFF_SUPV_THR:
                ok = in_range(wdata, relay_settings_pkg::SUPV_MIN,
                              relay_settings_pkg::SUPV_MAX);
            relay_settings_pkg::OFF_EVT_MASK_L, relay_settings_pkg::OFF_EVT_MASK_H:
                ok = 1'b1;
            default:
                ok = 1'b0; // unmapped or read-only target refuses the write
        endcase
    end

    logic accept;
    assign accept = wr_stb && ok;

    // settings store; a refused write leaves everything as held
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            flags    <= '0;
            scheme   <= relay_settings_pkg::SCH_SCALED;
            lpu_tmr  <= relay_settings_pkg::LPU_ADVISED;
            osb_tmr  <= relay_settings_pkg::RST_OSB;
            rod_tmr  <= '0;
            z1_tmr   <= relay_settings_pkg::RST_Z1_TMR;
            z2_tmr   <= relay_settings_pkg::RST_Z2_TMR;
            z3_tmr   <= relay_settings_pkg::RST_Z3_TMR;
            z1_reach <= '0;
            z2_reach <= '0;
            z3_reach <= relay_settings_pkg::RST_Z3_REACH;
            rcl_count <= '0;
            rcl_t1   <= relay_settings_pkg::RST_RCL_T;
            rcl_t2   <= relay_settings_pkg::RST_RCL_T;
            rcl_t3   <= relay_settings_pkg::RST_RCL_T;
            rcl_cond <= relay_settings_pkg::RST_RCL_T;
            dwell    <= relay_settings_pkg::RST_RCL_T;
            reset_tm <= relay_settings_pkg::RST_RCL_T;
            bkr_acc  <= '0;
            bkr_max  <= relay_settings_pkg::RST_BKR_MAX;
            supv_thr <= 32'(relay_settings_pkg::SUPV_MIN);
            evt_mask <= '1;
        end else if (accept) begin
            case (addr)
                relay_settings_pkg::OFF_FLAGS:
                    flags <= proposed_flags[relay_settings_pkg::FLAGS_W-1:0];
                relay_settings_pkg::OFF_SCHEME:     scheme   <= relay_settings_pkg::scheme_t'(wdata[1:0]);
                relay_settings_pkg::OFF_LPU_TMR:    lpu_tmr  <= wdata;
                relay_settings_pkg::OFF_OSB_TMR:    osb_tmr  <= wdata;
                relay_settings_pkg::OFF_ROD_TMR:    rod_tmr  <= wdata;
                relay_settings_pkg::OFF_Z1_TMR:     z1_tmr   <= wdata;
                relay_settings_pkg::OFF_Z2_TMR:     z2_tmr   <= wdata;
                relay_settings_pkg::OFF_Z3_TMR:     z3_tmr   <= wdata;
                relay_settings_pkg::OFF_Z1_REACH:   z1_reach <= wdata;
                relay_settings_pkg::OFF_Z2_REACH:   z2_reach <= wdata;
                relay_settings_pkg::OFF_Z3_REACH:   z3_reach <= wdata;
                relay_settings_pkg::OFF_RCL_COUNT:  rcl_count <= wdata;
                relay_settings_pkg::OFF_RCL_T1:     rcl_t1   <= wdata;
                relay_settings_pkg::OFF_RCL_T2:     rcl_t2   <= wdata;
                relay_settings_pkg::OFF_RCL_T3:     rcl_t3   <= wdata;
                relay_settings_pkg::OFF_RCL_COND:   rcl_cond <= wdata;
                relay_settings_pkg::OFF_DWELL:      dwell    <= wdata;
                relay_settings_pkg::OFF_RESET_TM:   reset_tm <= wdata;
                relay_settings_pkg::OFF_BKR_ACC:    bkr_acc  <= wdata;
                relay_settings_pkg::OFF_BKR_MAX:    bkr_max  <= wdata;
                relay_settings_pkg::OFF_SUPV_THR:   supv_thr <= wdata;
                relay_settings_pkg::OFF_EVT_MASK_L: evt_mask[31:0] <= wdata;
                relay_settings_pkg::OFF_EVT_MASK_H:
                    evt_mask[relay_settings_pkg::EVT_W-1:32] <=
                        wdata[relay_settings_pkg::EVT_W-33:0];
                default: ;
            endcase
        end
    end

    // outcome of the last write; reads leave it alone
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            last_reject <= 1'b0;
            last_accept <= 1'b0;
            reject_pulse <= 1'b0;
        end else begin
            reject_pulse <= wr_stb && !ok;
            if (wr_stb) begin
                last_reject <= !ok;
                last_accept <= ok;
            end
        end
    end

    // live status bits
    always_comb begin
        status[relay_settings_pkg::ST_REJECT] = last_reject;
        status[relay_settings_pkg::ST_ACCEPT] = last_accept;
        status[relay_settings_pkg::ST_RCL_OFF] = (rcl_count == '0);
        status[relay_settings_pkg::ST_LPU_ADV] = (lpu_tmr == relay_settings_pkg::LPU_ADVISED);
    end

    // read port: data one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata <= '0;
        end else if (rd_stb) begin
            case (addr)
                relay_settings_pkg::OFF_FLAGS:      rdata <= DATA_W'(flags);
                relay_settings_pkg::OFF_SCHEME:     rdata <= DATA_W'(scheme);
                relay_settings_pkg::OFF_LPU_TMR:    rdata <= lpu_tmr;
                relay_settings_pkg::OFF_OSB_TMR:    rdata <= osb_tmr;
                relay_settings_pkg::OFF_ROD_TMR:    rdata <= rod_tmr;
                relay_settings_pkg::OFF_Z1_TMR:     rdata <= z1_tmr;
                relay_settings_pkg::OFF_Z2_TMR:     rdata <= z2_tmr;
                relay_settings_pkg::OFF_Z3_TMR:     rdata <= z3_tmr;
                relay_settings_pkg::OFF_Z1_REACH:   rdata <= z1_reach;
                relay_settings_pkg::OFF_Z2_REACH:   rdata <= z2_reach;
                relay_settings_pkg::OFF_Z3_REACH:   rdata <= z3_reach;
                relay_settings_pkg::OFF_RCL_COUNT:  rdata <= rcl_count;
                relay_settings_pkg::OFF_RCL_T1:     rdata <= rcl_t1;
                relay_settings_pkg::OFF_RCL_T2:     rdata <= rcl_t2;
                relay_settings_pkg::OFF_RCL_T3:     rdata <= rcl_t3;
                relay_settings_pkg::OFF_RCL_COND:   rdata <= rcl_cond;
                relay_settings_pkg::OFF_DWELL:      rdata <= dwell;
                relay_settings_pkg::OFF_RESET_TM:   rdata <= reset_tm;
                relay_settings_pkg::OFF_BKR_ACC:    rdata <= bkr_acc;
                relay_settings_pkg::OFF_BKR_MAX:    rdata <= bkr_max;
                relay_settings_pkg::OFF_SUPV_THR:   rdata <= supv_thr;
                relay_settings_pkg::OFF_EVT_MASK_L: rdata <= evt_mask[31:0];
                relay_settings_pkg::OFF_EVT_MASK_H:
                    rdata <= DATA_W'(evt_mask[relay_settings_pkg::EVT_W-1:32]);
                relay_settings_pkg::OFF_STATUS:     rdata <= DATA_W'(status);
                default:                            rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // trip gate: master authorization over per-type enables
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            trip_out <= '0;
        end else begin
            trip_out.z1  <= flags[relay_settings_pkg::FLG_TRIP_AUTH] &&
                            flags[relay_settings_pkg::FLG_Z1_EN] && trip_s2.z1;
            trip_out.z2  <= flags[relay_settings_pkg::FLG_TRIP_AUTH] &&
                            flags[relay_settings_pkg::FLG_Z2_EN] && trip_s2.z2;
            trip_out.z3  <= flags[relay_settings_pkg::FLG_TRIP_AUTH] &&
                            flags[relay_settings_pkg::FLG_Z3_EN] && trip_s2.z3;
            trip_out.line_pickup_unit <= flags[relay_settings_pkg::FLG_TRIP_AUTH] &&
                            flags[relay_settings_pkg::FLG_LPU_EN] && trip_s2.line_pickup_unit;
            trip_out.remote_open_detector <= flags[relay_settings_pkg::FLG_TRIP_AUTH] &&
                            flags[relay_settings_pkg::FLG_ROD_EN] && trip_s2.remote_open_detector;
        end
    end

    // event recording gate, measuring unit supervision, scheme
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            evt_record                 <= '0;
            distance_measuring_unit_en <= 1'b0;
            scaled_distance_active     <= 1'b0;
        end else begin
            evt_record                 <= evt_s2 & evt_mask;
            distance_measuring_unit_en <= misc_s2[4];
            scaled_distance_active     <= 1'b1;
        end
    end

    // recloser permission and hold-off; count zero keeps it idle
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            reclose_allowed <= 1'b0;
            reclose_start   <= 1'b0;
        end else begin
            reclose_allowed <= (rcl_count != '0) &&
                ((flags[relay_settings_pkg::FLG_RCL_Z2] && (misc_s2[0] || misc_s2[1]))
                 || !(misc_s2[0] || misc_s2[1]));
            reclose_start <= (rcl_count != '0) && misc_s2[3] &&
                !(flags[relay_settings_pkg::FLG_WAIT_COND] && misc_s2[2]);
        end
    end

endmodule

//--- core/relay_settings_pkg.sv
// package for the relay setting checker and trip gate
// shared by the design and the bench; no imports assumed
package relay_settings_pkg;

    // register offsets (word index == byte address / 4)
    localparam logic [7:0] OFF_FLAGS      = 8'h00;
    localparam logic [7:0] OFF_SCHEME     = 8'h04;
    localparam logic [7:0] OFF_LPU_TMR    = 8'h08;
    localparam logic [7:0] OFF_OSB_TMR    = 8'h0c;
    localparam logic [7:0] OFF_ROD_TMR    = 8'h10;
    localparam logic [7:0] OFF_Z1_TMR     = 8'h14;
    localparam logic [7:0] OFF_Z2_TMR     = 8'h18;
    localparam logic [7:0] OFF_Z3_TMR     = 8'h1c;
    localparam logic [7:0] OFF_Z1_REACH   = 8'h20;
    localparam logic [7:0] OFF_Z2_REACH   = 8'h24;
    localparam logic [7:0] OFF_Z3_REACH   = 8'h28;
    localparam logic [7:0] OFF_RCL_COUNT  = 8'h2c;
    localparam logic [7:0] OFF_RCL_T1     = 8'h30;
    localparam logic [7:0] OFF_RCL_T2     = 8'h34;
    localparam logic [7:0] OFF_RCL_T3     = 8'h38;
    localparam logic [7:0] OFF_RCL_COND   = 8'h3c;
    localparam logic [7:0] OFF_DWELL      = 8'h40;
    localparam logic [7:0] OFF_RESET_TM   = 8'h44;
    localparam logic [7:0] OFF_BKR_ACC    = 8'h48;
    localparam logic [7:0] OFF_BKR_MAX    = 8'h4c;
    localparam logic [7:0] OFF_SUPV_THR   = 8'h50;
    localparam logic [7:0] OFF_EVT_MASK_L = 8'h54;
    localparam logic [7:0] OFF_EVT_MASK_H = 8'h58;
    localparam logic [7:0] OFF_STATUS     = 8'h5c;

    // bit positions in the flags register
    localparam int FLG_TRIP_AUTH  = 0;
    localparam int FLG_Z1_EN      = 1;
    localparam int FLG_Z2_EN      = 2;
    localparam int FLG_Z3_EN      = 3;
    localparam int FLG_LPU_EN     = 4;
    localparam int FLG_ROD_EN     = 5;
    localparam int FLG_INHIB_EN   = 6;
    localparam int FLG_CARRIER_EN = 7;
    localparam int FLG_WAIT_COND  = 8;
    localparam int FLG_RCL_Z2     = 9;
    localparam int FLG_RCL_Z3     = 10;
    localparam int FLAGS_W        = 11;

    // protection scheme codes
    typedef enum logic [1:0] {
        SCH_SCALED    = 2'h0,
        SCH_Z1_EXT    = 2'h1,
        SCH_Z2_ACCEL  = 2'h2
    } scheme_t;

    // ranges: timers in ms, recloser times in 10 ms units, threshold in 0.01 x rated
    localparam logic [31:0] LPU_MAX      = 32'd150;
    localparam logic [31:0] LPU_ADVISED  = 32'd128;
    localparam logic [31:0] OSB_MIN      = 32'd40;
    localparam logic [31:0] OSB_MAX      = 32'd200;
    localparam logic [31:0] ROD_MAX      = 32'd150;
    localparam logic [31:0] Z1_TMR_MAX   = 32'd500;
    localparam logic [31:0] Z2_TMR_MIN   = 32'd100;
    localparam logic [31:0] Z2_TMR_MAX   = 32'd3000;
    localparam logic [31:0] Z3_TMR_MIN   = 32'd100;
    localparam logic [31:0] Z3_TMR_MAX   = 32'd10000;
    localparam logic [31:0] Z3_MARGIN    = 32'd20;
    localparam logic [31:0] RCL_CNT_MAX  = 32'd3;
    localparam logic [31:0] RCL_T_MIN    = 32'd20;
    localparam logic [31:0] RCL_MISC_MIN = 32'd10;
    localparam logic [31:0] RCL_T_MAX    = 32'd9900;
    localparam logic [31:0] SUPV_MIN     = 32'd15;
    localparam logic [31:0] SUPV_MAX     = 32'd300;
    localparam logic [31:0] BKR_MAX_LIM  = 32'd100000;

    // reset values chosen to satisfy every cross check
    localparam logic [31:0] RST_Z1_TMR   = 32'd0;
    localparam logic [31:0] RST_Z2_TMR   = 32'd300;
    localparam logic [31:0] RST_Z3_TMR   = 32'd1000;
    localparam logic [31:0] RST_RCL_T    = 32'd100;
    localparam logic [31:0] RST_Z3_REACH = 32'd1000;
    localparam logic [31:0] RST_OSB      = 32'd40;
    localparam logic [31:0] RST_BKR_MAX  = 32'd100000;

    // event causes: trips, breaker, input disables, boots, supply
    localparam int EVT_W = 42;

    // status bits
    localparam int ST_REJECT   = 0;
    localparam int ST_ACCEPT   = 1;
    localparam int ST_RCL_OFF  = 2;
    localparam int ST_LPU_ADV  = 3;

    // trip requests from protection logic
    typedef struct packed {
        logic z1;
        logic z2;
        logic z3;
        logic line_pickup_unit;
        logic remote_open_detector;
    } trip_req_t;

    // bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

endpackage

//--- tb/relay_gate_asserts.sv
// port-level assertions for the setting checker and trip gate
// assumes inputs sit at 0 while reset_n is low; bound to every gate instance
`timescale 1ns/100ps
module relay_gate_asserts (
    input wire logic                          sys_clk, reset_n, wr_stb, rd_stb, reject_pulse,
    input wire logic [31:0]                   rdata,
    input wire relay_settings_pkg::trip_req_t trip_req, trip_out,
    input wire logic [41:0]                   evt_in, evt_record,
    input wire logic                          phase_current_gt, distance_measuring_unit_en,
    input wire logic                          reclose_init, reclose_start, scaled_distance_active
);
    // one domain, so clock and reset are declared once
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_read_idle: assert property (!$past(rd_stb) |-> rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_reject_cause: assert property (reject_pulse |-> $past(wr_stb))
        else $error("refusal without a write");
    a_trip_cause: assert property ((trip_out & ~$past(trip_req, 3)) == 5'h0)
        else $error("trip without request");
    a_trip_drop: assert property ($fell(trip_req.remote_open_detector) |-> ##3 !trip_out.remote_open_detector)
        else $error("remote open trip outlived request");
    a_event_mask: assert property ((evt_record & ~$past(evt_in, 3)) == 42'h0)
        else $error("event recorded without cause");
    a_meas_follow: assert property ($past(reset_n, 3) |->
        distance_measuring_unit_en == $past(phase_current_gt, 3))
        else $error("measuring enable not following supervision");
    a_reclose_init: assert property (reclose_start |-> $past(reclose_init, 3))
        else $error("reclose start without initiation");
    a_scaled_on: assert property ($past(reset_n) |-> scaled_distance_active)
        else $error("scaled distance inactive");
    cover property (reject_pulse);
    cover property (trip_out == 5'h1f);
    cover property ($rose(reclose_start));
endmodule
bind relay_setting_checker_trip_gate relay_gate_asserts relay_gate_asserts_i (.*);

//--- tb/settings_host.sv
// settings host model: one-cycle strobes on the plain register port
// assumes the slave never stalls and read data stand one cycle after rd_stb
`timescale 1ns/100ps
module settings_host (
    input wire logic   sys_clk,
    input wire logic [31:0] rdata,
    output logic [7:0]  addr,
    output logic [31:0] wdata,
    output logic        wr_stb,
    output logic        rd_stb
);
    initial begin
        {addr, wdata, wr_stb, rd_stb} = 42'h0;
    end
    // released data inverted so a stale bus never passes as held
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {addr, wdata, wr_stb} <= {a, d, 1'b1};
        @(posedge sys_clk);
        {wdata, wr_stb} <= {~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        {addr, rd_stb} <= {a, 1'b1};
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(posedge sys_clk);
        d = rdata;
    endtask
endmodule

//--- tb/tb.sv
// bench: setting refusals, readback, trip gating, recloser, events, supervision
// assumes relay_settings_pkg is compiled first; settings_host drives the bus
`timescale 1ns/100ps
module tb;
    logic sys_clk = 1'b0, reset_n = 1'b0, phase_current_gt = 1'b0, reclose_init = 1'b0;
    logic reclose_inhibit = 1'b0, rod_tripped = 1'b0, meas_en, reclose_start, reclose_allowed;
    logic reject_pulse, wr_stb, rd_stb;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, s;
    relay_settings_pkg::trip_req_t trip_req = 5'h0, trip_out;
    logic [41:0] evt_in = 42'h0, evt_record;
    logic [11:0] ft [4] = '{12'h1fe, 12'h1ff, 12'h1cb, 12'h3f1};
    logic [31:0] wt [$];
    int fail_count = 0, cmp_count = 0;
    always #12.5 sys_clk = ~sys_clk;
    relay_setting_checker_trip_gate relay_setting_checker_trip_gate_i (.sys_clk, .reset_n,
        .addr, .wdata, .wr_stb, .rd_stb, .rdata, .trip_req, .trip_out, .evt_in, .evt_record,
        .phase_current_gt, .distance_measuring_unit_en(meas_en), .reclose_init,
        .reclose_inhibit, .reclose_start, .rod_tripped, .z2_tripped(rod_tripped),
        .reclose_allowed, .scaled_distance_active(), .reject_pulse);
    settings_host settings_host_i (.sys_clk, .rdata, .addr, .wdata, .wr_stb, .rd_stb);
    task automatic chk(input string n, input logic [41:0] seen, input logic [41:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // hang guard
    initial begin
        #1000000;
        fail_count++;
        finish_test();
    end
    // entries: refuse nibble, byte address, value
    initial begin
        wt = {32'h1_08_00097, 32'h0_08_00080, 32'h1_0c_00027, 32'h1_0c_000c9,
            32'h0_0c_000c8, 32'h1_10_0012d, 32'h1_10_00097, 32'h0_10_00096,
            32'h1_14_001f5, 32'h0_14_001f4, 32'h1_18_00063, 32'h1_18_003d5,
            32'h0_18_003d4, 32'h1_1c_02711, 32'h1_1c_003e7, 32'h1_20_003e9,
            32'h1_24_003e9, 32'h1_2c_00004, 32'h0_2c_00003, 32'h1_30_00013,
            32'h1_38_026ad, 32'h0_34_00014, 32'h1_3c_00009, 32'h0_40_0000a,
            32'h0_4c_00032, 32'h1_48_00033, 32'h0_48_00032, 32'h1_50_0000e,
            32'h1_50_0012d, 32'h0_50_0012c, 32'h0_00_001c0, 32'h1_00_00180,
            32'h0_04_00002, 32'h1_00_00140, 32'h1_04_00003, 32'h0_04_00001,
            32'h1_44_00061, 32'h0_44_00062, 32'h0_10_00064, 32'h0_18_00064,
            32'h1_10_00065, 32'h1_5c_00000, 32'h1_60_00000};
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (wt[i]) begin
            settings_host_i.wr(wt[i][27:20], {12'h0, wt[i][19:0]});
            settings_host_i.rd(8'h5c, s);
            chk("status refused", s[0], wt[i][28]);
        end
        settings_host_i.rd(8'h0c, s);
        chk("block timer", s, 32'hc8);
        settings_host_i.rd(8'h10, s);
        chk("remote open timer", s, 32'h64);
        $display("test settings done");
        settings_host_i.wr(8'h54, 32'hff);
        {trip_req, evt_in, phase_current_gt} <= {5'h1f, {42{1'b1}}, 1'b1};
        {reclose_init, reclose_inhibit, rod_tripped} <= 3'h7;
        foreach (ft[i]) begin
            settings_host_i.wr(8'h00, {20'h0, ft[i]});
            repeat (4) @(posedge sys_clk);
            #1;
            chk("trip", trip_out, {ft[i][1], ft[i][2], ft[i][3], ft[i][4], ft[i][5]}
                & {5{ft[i][0]}});
            chk("reclose allowed", reclose_allowed, ft[i][9]);
            chk("reclose held", reclose_start, 1'b0);
        end
        @(posedge sys_clk);
        reclose_inhibit <= 1'b0;
        trip_req.remote_open_detector <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("reclose start", reclose_start, 1'b1);
        chk("event record", evt_record, {10'h3ff, 32'hff});
        chk("measuring enable", meas_en, 1'b1);
        $display("test gate done");
        finish_test();
    end
endmodule
